/* src/bar_params.svh */
// constants for the bridge address remapper: register byte offsets, field
// positions, reset values. assumes a 32-bit ahb-lite register slave.
//
// Operation
// - claimed downstream i/o cycles drop every bit above the 25-bit i/o space, and as many more upper bits as the i/o size setting says.
// - memory cycles are claimed downstream only by the primary base and limit settings.
// - a non-prefetchable hit goes out at its address minus (primary minus secondary base).
// - a prefetchable hit goes out at its address minus (primary minus secondary base).
// - each secondary window limit is the primary limit minus that window's offset.
// - upstream cycles inside a shifted secondary memory window are not claimed.
// - each dma offset is primary dma base minus secondary dma base over its secondary range.
// - each dma window's primary image ends at the secondary limit plus its offset.
// - an upstream cycle inside a dma window goes up with the dma offset added.
// - upstream cycles outside every dma and memory window go up unchanged.
`ifndef BAR_PARAMS_SVH
`define BAR_PARAMS_SVH

`define BAR_OFF_CTRL 12'h000
`define BAR_OFF_IO_SIZE 12'h004
`define BAR_OFF_IO_BASE 12'h008
`define BAR_OFF_IO_LIMIT 12'h00C
`define BAR_OFF_NP_PRI_BASE 12'h010
`define BAR_OFF_NP_PRI_LIMIT 12'h014
`define BAR_OFF_NP_SEC_BASE 12'h018
`define BAR_OFF_NP_SEC_LIMIT 12'h01C
`define BAR_OFF_PF_PRI_BASE 12'h020
`define BAR_OFF_PF_PRI_LIMIT 12'h024
`define BAR_OFF_PF_SEC_BASE 12'h028
`define BAR_OFF_PF_SEC_LIMIT 12'h02C
`define BAR_OFF_LAST_DS 12'h030
`define BAR_OFF_LAST_US 12'h034
// dma window n sits at BAR_OFF_DMA0 + n * BAR_DMA_STRIDE
`define BAR_OFF_DMA0 12'h040
`define BAR_DMA_STRIDE 12'h010
`define BAR_DMA_SEC_BASE 2'h0
`define BAR_DMA_SEC_LIMIT 2'h1
`define BAR_DMA_PRI_BASE 2'h2
`define BAR_DMA_PRI_LIMIT 2'h3

`define BAR_CTRL_REMAP_EN 0
`define BAR_CTRL_VGA_EN 1
`define BAR_CTRL_ISA_EN 2
`define BAR_CTRL_W 3
`define BAR_IO_SIZE_W 5
// i/o addresses are this wide; the size setting trims from the top of this space
`define BAR_IO_ADDR_W 25

`define BAR_RST_CTRL 3'h0
`define BAR_RST_WORD 32'h0000_0000
`define BAR_RST_IO_SIZE 5'h00

`endif

/* src/bar_pkg.sv */
// types shared by the bridge address remapper.
// assumes a 32-bit address on both sides of the bridge.
`default_nettype none
package bar_pkg;
    typedef logic [31:0] bar_word_t;
    // kind of a translated downstream cycle
    typedef enum logic [1:0] {
        BAR_KIND_NONE = 2'b00,
        BAR_KIND_IO = 2'b01,
        BAR_KIND_NP = 2'b10,
        BAR_KIND_PF = 2'b11
    } bar_kind_e;
endpackage
`default_nettype wire

/* src/bar_remap.sv */
// bridge address remapper: i/o aliasing, memory window mapping and dma window
// remapping, programmed over ahb-lite. expects one cycle per request in each
// direction; answers come one clock later from flip-flops.
`default_nettype none
`include "bar_params.svh"

module bar_remap #(
    parameter int NDMA = 2
) (
    // clock, reset, enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // downstream request from the primary side
    input wire logic ds_valid,
    input wire logic ds_is_io,
    input wire logic [31:0] ds_addr,
    // downstream answer toward the secondary bus
    output logic ds_out_valid,
    output logic ds_out_claim,
    output bar_pkg::bar_kind_e ds_out_kind,
    output logic [31:0] ds_out_addr,
    // upstream request from the secondary bus
    input wire logic us_valid,
    input wire logic [31:0] us_addr,
    // upstream answer toward the primary side
    output logic us_out_valid,
    output logic us_out_claim,
    output logic us_out_dma_hit,
    output logic [31:0] us_out_addr
);

    // ==========================================================
    // register bus
    logic [`BAR_CTRL_W-1:0] ctrl_r;
    logic [`BAR_IO_SIZE_W-1:0] io_size_r;
    bar_pkg::bar_word_t io_base_r, io_limit_r;
    bar_pkg::bar_word_t np_pri_base_r, np_pri_limit_r, np_sec_base_r;
    bar_pkg::bar_word_t pf_pri_base_r, pf_pri_limit_r, pf_sec_base_r;
    bar_pkg::bar_word_t last_ds_r, last_us_r;
    bar_pkg::bar_word_t dma_sec_base_r [NDMA];
    bar_pkg::bar_word_t dma_sec_limit_r [NDMA];
    bar_pkg::bar_word_t dma_pri_base_r [NDMA];

    logic wr_pend_r;
    logic [11:0] wr_addr_r;
    logic [31:0] hrdata_r;
    logic [31:0] rd_nxt;

    wire addr_phase = hsel && htrans[1] && hready;
    // a write lands at the end of its data phase, when hwdata stands
    wire wr_take = ce && wr_pend_r;
    // whole-word registers only; hsize is accepted but not used to mask lanes
    wire unused_hsize = ^hsize;

    // no wait states: every word is a flip-flop or a short sum of three
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;

    wire wr_ctrl = wr_take && wr_addr_r == `BAR_OFF_CTRL;
    wire wr_io_size = wr_take && wr_addr_r == `BAR_OFF_IO_SIZE;
    wire wr_io_base = wr_take && wr_addr_r == `BAR_OFF_IO_BASE;
    wire wr_io_limit = wr_take && wr_addr_r == `BAR_OFF_IO_LIMIT;
    wire wr_np_pb = wr_take && wr_addr_r == `BAR_OFF_NP_PRI_BASE;
    wire wr_np_pl = wr_take && wr_addr_r == `BAR_OFF_NP_PRI_LIMIT;
    wire wr_np_sb = wr_take && wr_addr_r == `BAR_OFF_NP_SEC_BASE;
    wire wr_pf_pb = wr_take && wr_addr_r == `BAR_OFF_PF_PRI_BASE;
    wire wr_pf_pl = wr_take && wr_addr_r == `BAR_OFF_PF_PRI_LIMIT;
    wire wr_pf_sb = wr_take && wr_addr_r == `BAR_OFF_PF_SEC_BASE;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 12'h000;
            hrdata_r <= `BAR_RST_WORD;
        end else if (ce) begin
            wr_pend_r <= addr_phase && hwrite;
            wr_addr_r <= haddr;
            // read data is fetched in the address phase; the master never reads
            // straight after a write to the same word, so no forwarding is kept
            if (addr_phase && !hwrite) begin
                hrdata_r <= rd_nxt;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= `BAR_RST_CTRL;
            io_size_r <= `BAR_RST_IO_SIZE;
            io_base_r <= `BAR_RST_WORD;
            io_limit_r <= `BAR_RST_WORD;
        end else begin
            if (wr_ctrl) ctrl_r <= hwdata[`BAR_CTRL_W-1:0];
            if (wr_io_size) io_size_r <= hwdata[`BAR_IO_SIZE_W-1:0];
            if (wr_io_base) io_base_r <= hwdata;
            if (wr_io_limit) io_limit_r <= hwdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            np_pri_base_r <= `BAR_RST_WORD;
            np_pri_limit_r <= `BAR_RST_WORD;
            np_sec_base_r <= `BAR_RST_WORD;
            pf_pri_base_r <= `BAR_RST_WORD;
            pf_pri_limit_r <= `BAR_RST_WORD;
            pf_sec_base_r <= `BAR_RST_WORD;
        end else begin
            if (wr_np_pb) np_pri_base_r <= hwdata;
            if (wr_np_pl) np_pri_limit_r <= hwdata;
            if (wr_np_sb) np_sec_base_r <= hwdata;
            if (wr_pf_pb) pf_pri_base_r <= hwdata;
            if (wr_pf_pl) pf_pri_limit_r <= hwdata;
            if (wr_pf_sb) pf_sec_base_r <= hwdata;
        end
    end

    // ==========================================================
    // window arithmetic
    wire remap_en = ctrl_r[`BAR_CTRL_REMAP_EN];
    // legacy decode enables are only stored: software keeps them clear
    // legacy enables unused
    wire unused_legacy = ctrl_r[`BAR_CTRL_VGA_EN] ^ ctrl_r[`BAR_CTRL_ISA_EN];

    wire [31:0] np_off = np_pri_base_r - np_sec_base_r;
    wire [31:0] pf_off = pf_pri_base_r - pf_sec_base_r;
    wire [31:0] np_sec_limit = np_pri_limit_r - np_off;
    wire [31:0] pf_sec_limit = pf_pri_limit_r - pf_off;

    // ==========================================================
    // dma windows
    // with base and limit both cleared a window still covers address zero, so
    // software programs every window before it sets the remap enable
    logic [NDMA-1:0] dma_hit;
    logic [31:0] dma_off [NDMA];
    logic [31:0] dma_pri_limit [NDMA];

    // each window owns four words: secondary base, limit, primary base, primary end
    genvar g;
    generate
        for (g = 0; g < NDMA; g++) begin : g_dma
            localparam logic [11:0] BASE = `BAR_OFF_DMA0 + 12'(g) * `BAR_DMA_STRIDE;
            wire wsel = wr_take && wr_addr_r[11:4] == BASE[11:4];
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    dma_sec_base_r[g] <= `BAR_RST_WORD;
                    dma_sec_limit_r[g] <= `BAR_RST_WORD;
                    dma_pri_base_r[g] <= `BAR_RST_WORD;
                end else if (wsel) begin
                    if (wr_addr_r[3:2] == `BAR_DMA_SEC_BASE) dma_sec_base_r[g] <= hwdata;
                    if (wr_addr_r[3:2] == `BAR_DMA_SEC_LIMIT) dma_sec_limit_r[g] <= hwdata;
                    if (wr_addr_r[3:2] == `BAR_DMA_PRI_BASE) dma_pri_base_r[g] <= hwdata;
                end
            end
            assign dma_off[g] = dma_pri_base_r[g] - dma_sec_base_r[g];
            assign dma_pri_limit[g] = dma_sec_limit_r[g] + dma_off[g];
            assign dma_hit[g] = us_addr >= dma_sec_base_r[g] && us_addr <= dma_sec_limit_r[g];
        end
    endgenerate

    // ==========================================================
    // downstream path
    // claim by primary windows
    wire ds_np_hit = ds_addr >= np_pri_base_r && ds_addr <= np_pri_limit_r;
    wire ds_pf_hit = ds_addr >= pf_pri_base_r && ds_addr <= pf_pri_limit_r;
    wire ds_io_hit = ds_addr >= io_base_r && ds_addr <= io_limit_r;
    // the i/o space is narrower than a memory address, so bits above it never
    // reach the secondary bus; the size setting then trims from its top
    wire [31:0] io_space_mask = 32'hFFFF_FFFF >> (32 - `BAR_IO_ADDR_W);
    wire [31:0] io_mask = io_space_mask >> io_size_r;
    wire [31:0] ds_io_addr = ds_addr & io_mask;
    wire [31:0] ds_np_addr = remap_en ? ds_addr - np_off : ds_addr;
    wire [31:0] ds_pf_addr = remap_en ? ds_addr - pf_off : ds_addr;

    // an i/o cycle never falls into a memory window, nor a memory cycle into the i/o one
    wire ds_claim = ds_is_io ? ds_io_hit : (ds_np_hit || ds_pf_hit);
    wire bar_pkg::bar_kind_e ds_kind = !ds_claim ? bar_pkg::BAR_KIND_NONE :
        ds_is_io ? bar_pkg::BAR_KIND_IO :
        ds_np_hit ? bar_pkg::BAR_KIND_NP : bar_pkg::BAR_KIND_PF;
    wire [31:0] ds_addr_nxt = !ds_claim ? ds_addr :
        ds_is_io ? ds_io_addr :
        ds_np_hit ? ds_np_addr : ds_pf_addr;

    // ==========================================================
    // upstream path
    // shifted windows not claimed
    wire us_in_np = us_addr >= np_sec_base_r && us_addr <= np_sec_limit;
    wire us_in_pf = us_addr >= pf_sec_base_r && us_addr <= pf_sec_limit;
    // with remapping off the secondary windows sit where the primary ones do
    wire us_in_pri_np = us_addr >= np_pri_base_r && us_addr <= np_pri_limit_r;
    wire us_in_pri_pf = us_addr >= pf_pri_base_r && us_addr <= pf_pri_limit_r;
    wire us_claim = !(remap_en ? (us_in_np || us_in_pf) : (us_in_pri_np || us_in_pri_pf));

    // lowest-numbered window wins; overlapping dma windows are a software error
    logic [31:0] us_dma_addr;
    always_comb begin
        us_dma_addr = us_addr;
        for (int i = NDMA - 1; i >= 0; i--) begin
            if (dma_hit[i]) us_dma_addr = us_addr + dma_off[i];
        end
    end
    wire us_dma_any = remap_en && |dma_hit;
    wire [31:0] us_addr_nxt = us_dma_any ? us_dma_addr : us_addr;

    // ==========================================================
    // translated answers, also kept as the last address for software

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ds_out_valid <= 1'b0;
            ds_out_claim <= 1'b0;
            ds_out_kind <= bar_pkg::BAR_KIND_NONE;
            ds_out_addr <= `BAR_RST_WORD;
            last_ds_r <= `BAR_RST_WORD;
        end else if (ce) begin
            ds_out_valid <= ds_valid;
            if (ds_valid) begin
                ds_out_claim <= ds_claim;
                ds_out_kind <= ds_kind;
                ds_out_addr <= ds_addr_nxt;
                last_ds_r <= ds_addr_nxt;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            us_out_valid <= 1'b0;
            us_out_claim <= 1'b0;
            us_out_dma_hit <= 1'b0;
            us_out_addr <= `BAR_RST_WORD;
            last_us_r <= `BAR_RST_WORD;
        end else if (ce) begin
            us_out_valid <= us_valid;
            if (us_valid) begin
                us_out_claim <= us_claim;
                us_out_dma_hit <= us_dma_any && us_claim;
                us_out_addr <= us_addr_nxt;
                last_us_r <= us_addr_nxt;
            end
        end
    end

    // ==========================================================
    // read mux
    always_comb begin
        rd_nxt = 32'h0000_0000;
        unique case (haddr)
            `BAR_OFF_CTRL: rd_nxt = {29'h0000_0000, ctrl_r};
            `BAR_OFF_IO_SIZE: rd_nxt = {27'h000_0000, io_size_r};
            `BAR_OFF_IO_BASE: rd_nxt = io_base_r;
            `BAR_OFF_IO_LIMIT: rd_nxt = io_limit_r;
            `BAR_OFF_NP_PRI_BASE: rd_nxt = np_pri_base_r;
            `BAR_OFF_NP_PRI_LIMIT: rd_nxt = np_pri_limit_r;
            `BAR_OFF_NP_SEC_BASE: rd_nxt = np_sec_base_r;
            `BAR_OFF_NP_SEC_LIMIT: rd_nxt = np_sec_limit;
            `BAR_OFF_PF_PRI_BASE: rd_nxt = pf_pri_base_r;
            `BAR_OFF_PF_PRI_LIMIT: rd_nxt = pf_pri_limit_r;
            `BAR_OFF_PF_SEC_BASE: rd_nxt = pf_sec_base_r;
            `BAR_OFF_PF_SEC_LIMIT: rd_nxt = pf_sec_limit;
            `BAR_OFF_LAST_DS: rd_nxt = last_ds_r;
            `BAR_OFF_LAST_US: rd_nxt = last_us_r;
            default: rd_nxt = 32'h0000_0000;
        endcase
        // dma words lie outside the fixed map, so the default above never hides them
        for (int i = 0; i < NDMA; i++) begin
            if (haddr[11:4] == 8'(({20'h0, `BAR_OFF_DMA0} + 32'(i) * 32'h10) >> 4)) begin
                unique case (haddr[3:2])
                    `BAR_DMA_SEC_BASE: rd_nxt = dma_sec_base_r[i];
                    `BAR_DMA_SEC_LIMIT: rd_nxt = dma_sec_limit_r[i];
                    `BAR_DMA_PRI_BASE: rd_nxt = dma_pri_base_r[i];
                    `BAR_DMA_PRI_LIMIT: rd_nxt = dma_pri_limit[i];
                endcase
            end
        end
    end

endmodule
`default_nettype wire

/* verif/bar_remap_props.sv */
// concurrent checks on the address remapper's ports.
// assumes it is bound to bar_remap; one clock domain.
`default_nettype none
module bar_remap_props #(
    parameter int NDMA = 2
) (
    // clock, reset, enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // downstream
    input wire logic ds_valid,
    input wire logic ds_is_io,
    input wire logic [31:0] ds_addr,
    input wire logic ds_out_valid,
    input wire logic ds_out_claim,
    input wire bar_pkg::bar_kind_e ds_out_kind,
    input wire logic [31:0] ds_out_addr,
    // upstream
    input wire logic us_valid,
    input wire logic [31:0] us_addr,
    input wire logic us_out_valid,
    input wire logic us_out_claim,
    input wire logic us_out_dma_hit,
    input wire logic [31:0] us_out_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    // ========================================
    // request sequences
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    sequence ds_take;
        ce && ds_valid;
    endsequence
    sequence us_take;
        ce && us_valid;
    endsequence
    // ========================================
    // properties
    a_ds_answer: assert property (ds_take |=> ds_out_valid)
        else $error("downstream answer missing");
    a_ds_no_extra: assert property (ce && !ds_valid |=> !ds_out_valid)
        else $error("downstream answer without request");
    a_us_answer: assert property (us_take |=> us_out_valid)
        else $error("upstream answer missing");
    a_io_kind_only: assert property (ds_take and ds_is_io |=>
        ds_out_kind inside {bar_pkg::BAR_KIND_NONE, bar_pkg::BAR_KIND_IO})
        else $error("i/o cycle given a memory kind");
    a_claim_by_kind: assert property (ds_out_valid |->
        ds_out_claim == (ds_out_kind != bar_pkg::BAR_KIND_NONE))
        else $error("claim and kind disagree");
    a_ds_pass_unclaimed: assert property (ds_take ##1 !ds_out_claim |->
        ds_out_addr == $past(ds_addr))
        else $error("unclaimed downstream address changed");
    a_dma_hit_claimed: assert property (us_out_dma_hit |-> us_out_claim)
        else $error("dma hit on an unclaimed cycle");
    a_us_pass_plain: assert property (us_take ##1 (us_out_claim && !us_out_dma_hit) |->
        us_out_addr == $past(us_addr))
        else $error("plain upstream address changed");
    a_ds_fields_hold: assert property (ce && !ds_valid |=> $stable(ds_out_addr))
        else $error("downstream address moved between requests");
endmodule
`default_nettype wire

/* verif/bar_sec_model.sv */
// secondary bus model: issues upstream memory cycles toward the bridge.
// assumes hclk is the bridge clock; a released address shows its inverse.
`default_nettype none
module bar_sec_model (
    // clock
    input wire logic hclk,
    // upstream request
    output logic us_valid,
    output logic [31:0] us_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        us_valid = 1'b0;
        us_addr = 32'h0000_0000;
    end
    // inverse after release so a stale address is never mistaken for a held one
    task automatic send(input logic [31:0] a);
        @(posedge hclk);
        us_valid <= 1'b1;
        us_addr <= a;
        @(posedge hclk);
        us_valid <= 1'b0;
        us_addr <= ~a;
    endtask
endmodule
`default_nettype wire

/* verif/test_bar_remap.sv */
// bench for the address remapper: programs windows over ahb-lite, then
// checks downstream and upstream translation; assumes one-cycle answers.
`default_nettype none
module test_bar_remap;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NDMA = 2;
    logic hclk = 1'b0, hresetn = 1'b0, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, hrdata, ds_addr = 32'h0, ds_out_addr, us_addr, us_out_addr, rd;
    logic ds_valid = 1'b0, ds_is_io = 1'b0, hreadyout, hresp, ds_out_valid, ds_out_claim;
    logic us_valid, us_out_valid, us_out_claim, us_out_dma_hit;
    bar_pkg::bar_kind_e ds_out_kind;
    int err_total = 0;
    int total_checks = 0;

    bar_remap #(.NDMA(NDMA)) i_bar_remap (
        .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .ds_valid(ds_valid), .ds_is_io(ds_is_io), .ds_addr(ds_addr),
        .ds_out_valid(ds_out_valid), .ds_out_claim(ds_out_claim),
        .ds_out_kind(ds_out_kind), .ds_out_addr(ds_out_addr), .us_valid(us_valid),
        .us_addr(us_addr), .us_out_valid(us_out_valid), .us_out_claim(us_out_claim),
        .us_out_dma_hit(us_out_dma_hit), .us_out_addr(us_out_addr)
    );
    bar_sec_model i_bar_sec_model (.hclk(hclk), .us_valid(us_valid), .us_addr(us_addr));

    initial begin
        forever #20 hclk = ~hclk;
    end

    // ========================================
    // report and compare
    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // ========================================
    // ahb-lite master; entered just after a rising edge
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 64) begin
                err_total++;
                end_sim();
            end
            @(posedge hclk);
        end
    endtask
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        hsel <= 1'b1;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
        chk({31'h0, hresp}, 32'h0);
    endtask

    // ========================================
    // translation requests; answer looked at in the cycle after
    task automatic ds(input logic io, input logic [31:0] a, input logic cl,
                      input bar_pkg::bar_kind_e k, input logic [31:0] exp);
        ds_valid <= 1'b1;
        ds_is_io <= io;
        ds_addr <= a;
        @(posedge hclk);
        ds_valid <= 1'b0;
        ds_addr <= ~a;
        #1;
        chk({28'h0, ds_out_valid, ds_out_claim, ds_out_kind}, {28'h0, 1'b1, cl, k});
        chk(ds_out_addr, exp);
        @(posedge hclk);
    endtask
    task automatic us(input logic [31:0] a, input logic cl, input logic hit,
                      input logic [31:0] exp);
        i_bar_sec_model.send(a);
        #1;
        chk({29'h0, us_out_valid, us_out_claim, us_out_dma_hit}, {29'h0, 1'b1, cl, hit});
        chk(us_out_addr, exp);
        @(posedge hclk);
    endtask

    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc(12'h000, 32'h0);
        rdc(12'h004, 32'h0);
        bus(1'b1, 12'h000, 32'h0000_0001);
        bus(1'b1, 12'h004, 32'h0000_0006);
        bus(1'b1, 12'h008, 32'h0010_0000);
        bus(1'b1, 12'h00C, 32'h0017_FFFF);
        bus(1'b1, 12'h010, 32'h8000_0000);
        bus(1'b1, 12'h014, 32'hBFFF_FFFF);
        bus(1'b1, 12'h018, 32'h0000_0000);
        bus(1'b1, 12'h020, 32'hC000_0000);
        bus(1'b1, 12'h024, 32'hEFFF_FFFF);
        bus(1'b1, 12'h028, 32'h00C0_0000);
        // dma windows clear of memory windows on both sides
        bus(1'b1, 12'h040, 32'h5000_0000);
        bus(1'b1, 12'h044, 32'h5FFF_FFFF);
        bus(1'b1, 12'h048, 32'h1000_0000);
        bus(1'b1, 12'h050, 32'h6000_0000);
        bus(1'b1, 12'h054, 32'h6000_FFFF);
        bus(1'b1, 12'h058, 32'h7000_0000);
        bus(1'b1, 12'h01C, 32'h0000_0000);
        rdc(12'h01C, 32'h3FFF_FFFF);
        rdc(12'h02C, 32'h30BF_FFFF);
        rdc(12'h04C, 32'h1FFF_FFFF);
        rdc(12'h05C, 32'h7000_FFFF);
        rdc(12'h0FC, 32'h0);
        rdc(12'h000, 32'h1);
        ds(1'b1, 32'h0012_3456, 1'b1, bar_pkg::BAR_KIND_IO, 32'h0002_3456);
        ds(1'b1, 32'h0017_FFFF, 1'b1, bar_pkg::BAR_KIND_IO, 32'h0007_FFFF);
        ds(1'b1, 32'h0018_0000, 1'b0, bar_pkg::BAR_KIND_NONE, 32'h0018_0000);
        ds(1'b0, 32'h8000_1000, 1'b1, bar_pkg::BAR_KIND_NP, 32'h0000_1000);
        ds(1'b0, 32'hBFFF_FFFF, 1'b1, bar_pkg::BAR_KIND_NP, 32'h3FFF_FFFF);
        ds(1'b0, 32'hC000_0000, 1'b1, bar_pkg::BAR_KIND_PF, 32'h00C0_0000);
        ds(1'b0, 32'hEFFF_FFFF, 1'b1, bar_pkg::BAR_KIND_PF, 32'h30BF_FFFF);
        ds(1'b0, 32'hF000_0000, 1'b0, bar_pkg::BAR_KIND_NONE, 32'hF000_0000);
        us(32'h5000_0000, 1'b1, 1'b1, 32'h1000_0000);
        us(32'h5FFF_FFFF, 1'b1, 1'b1, 32'h1FFF_FFFF);
        us(32'h6000_FFFF, 1'b1, 1'b1, 32'h7000_FFFF);
        us(32'h6001_0000, 1'b1, 1'b0, 32'h6001_0000);
        us(32'h0000_1000, 1'b0, 1'b0, 32'h0000_1000);
        us(32'h3FFF_FFFF, 1'b0, 1'b0, 32'h3FFF_FFFF);
        us(32'h4000_0000, 1'b1, 1'b0, 32'h4000_0000);
        // with remapping off the primary window still claims, unshifted
        bus(1'b1, 12'h000, 32'h0);
        ds(1'b0, 32'h8000_1000, 1'b1, bar_pkg::BAR_KIND_NP, 32'h8000_1000);
        us(32'h5000_0000, 1'b1, 1'b0, 32'h5000_0000);
        end_sim();
    end
endmodule

bind bar_remap bar_remap_props #(.NDMA(NDMA)) i_bar_remap_props (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .ds_valid(ds_valid), .ds_is_io(ds_is_io),
    .ds_addr(ds_addr), .ds_out_valid(ds_out_valid), .ds_out_claim(ds_out_claim),
    .ds_out_kind(ds_out_kind), .ds_out_addr(ds_out_addr), .us_valid(us_valid),
    .us_addr(us_addr), .us_out_valid(us_out_valid), .us_out_claim(us_out_claim),
    .us_out_dma_hit(us_out_dma_hit), .us_out_addr(us_out_addr)
);
`default_nettype wire
